//--- verilog/lop_pkg.sv
package lop_pkg;

  // ==========================================================
  // clock and pwm timing
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned FREQ_SLOW_HZ     = 170;
  localparam int unsigned FREQ_FAST_HZ     = 225;
  localparam int unsigned SLOTS_PER_PERIOD = 128;
  localparam int unsigned TICKS_PER_PERIOD = 1024;
  localparam int unsigned TICK_W           = 10;
  localparam int unsigned PRE_W            = 13;
  localparam int unsigned THR_W            = 11;
  localparam int unsigned SLOT_SHIFT       = 3;
  localparam int unsigned PRE_SLOW_INT     = CLK_HZ / (FREQ_SLOW_HZ * TICKS_PER_PERIOD);
  localparam int unsigned PRE_FAST_INT     = CLK_HZ / (FREQ_FAST_HZ * TICKS_PER_PERIOD);
  localparam logic [PRE_W-1:0] PRE_SLOW_LAST = PRE_W'(PRE_SLOW_INT - 1);
  localparam logic [PRE_W-1:0] PRE_FAST_LAST = PRE_W'(PRE_FAST_INT - 1);

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_AB = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_CD = 8'h09;
  localparam logic [DATA_W-1:0] DUTY_RESET   = 16'h0000;
  localparam int unsigned NUM_CH = 4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       freq_sel;
    logic [6:0] duty_field;
  } lop_chan_cfg_t;

  typedef struct packed {
    lop_chan_cfg_t hi;
    lop_chan_cfg_t lo;
  } lop_duty_pair_t;

  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lop_reg_req_t;

endpackage

//--- verilog/lop_pwm_channel.sv
`timescale 1ns/10ps
`default_nettype none
module lop_pwm_channel (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       freq_sel,
  input  wire logic       fine_en,
  input  wire logic [6:0] duty_coarse,
  input  wire logic [9:0] duty_fine,
  output logic            pwm_out
);

  // ==========================================================
  // prescaler and period counter
  localparam int unsigned THR_W = lop_pkg::THR_W;

  logic [lop_pkg::PRE_W-1:0]  pre_q;
  logic [lop_pkg::TICK_W-1:0] tick_q;
  logic [lop_pkg::PRE_W-1:0]  pre_last;
  logic [lop_pkg::THR_W-1:0]  thr;
  logic                       pwm_q;
  logic                       tick_stb;

  assign pre_last = freq_sel ? lop_pkg::PRE_FAST_LAST : lop_pkg::PRE_SLOW_LAST;
  // >= so a switch to the faster rate mid-tick cannot overrun
  assign tick_stb = (pre_q >= pre_last);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pre_q <= '0;
    else if (tick_stb)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  // 1024 ticks give 128 slots of 8 ticks each, shared with fine mode
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      tick_q <= '0;
    else if (tick_stb)
      tick_q <= tick_q + 1'b1;
  end

  // ==========================================================
  // compare
  always_comb
  begin
    if (fine_en)
      thr = {1'b0, duty_fine} + 1'b1;
    else
      thr = THR_W'(({4'b0, duty_coarse} + 1'b1) << lop_pkg::SLOT_SHIFT);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pwm_q <= 1'b0;
    else
      pwm_q <= ({1'b0, tick_q} < thr);
  end

  assign pwm_out = pwm_q;

  // ==========================================================
  // checks
  property p_duty_compare;
    @(posedge ref_clk) disable iff (reset)
      !$past(reset) && !$past(fine_en) |->
        pwm_q == ($past(tick_q >> lop_pkg::SLOT_SHIFT) <= $past(duty_coarse));
  endproperty
  a_duty_compare: assert property (p_duty_compare) else $error("pwm level wrong");

  property p_pre_bound;
    @(posedge ref_clk) disable iff (reset)
      $stable(freq_sel) && !$past(reset) |-> pre_q <= pre_last;
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("prescaler overrun");

  property p_fast_tick;
    @(posedge ref_clk) disable iff (reset)
      // a host may drop the fast rate mid-tick; only a held fast rate is judged
      freq_sel && pre_q == '0 && $past(tick_stb) |-> ##[433:434] (tick_stb || !freq_sel);
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("fast tick spacing wrong");

  property p_fine_thr;
    @(posedge ref_clk) disable iff (reset)
      !$past(reset) && $past(fine_en) |-> pwm_q == ($past(tick_q) <= $past(duty_fine));
  endproperty
  a_fine_thr: assert property (p_fine_thr) else $error("fine threshold wrong");

  c_wrap: cover property (@(posedge ref_clk) tick_stb && tick_q == '1);

endmodule
`default_nettype wire

//--- verilog/lop_lamp_pwm_unit.sv
// Overview of operation
// - internal generator drives a lamp output only while its source bit is set.
// - on-time fraction equals duty field plus one over 128.
// - frequency bit picks 170 Hz when clear, 225 Hz when set, per channel.
// - fine resolution enable takes 10-bit per-channel duty instead of packed field.
// - register 08h holds A in upper byte, B in lower byte.
// - register 09h holds C in upper byte, D in lower byte.
// - reset clears both packed duty registers to zero.
// - both registers fully read/write, reads return last write, no side effects.
// - external pwm selection makes the output follow the external input level.
`timescale 1ns/10ps
`default_nettype none
module lop_lamp_pwm_unit (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire lop_pkg::lop_reg_req_t        reg_req,
  output logic [lop_pkg::DATA_W-1:0]        reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic [lop_pkg::NUM_CH-1:0]   internal_pwm_source_sel,
  input  wire logic                         fine_resolution_enable,
  input  wire logic [9:0]                   fine_duty_a,
  input  wire logic [9:0]                   fine_duty_b,
  input  wire logic [9:0]                   fine_duty_c,
  input  wire logic [9:0]                   fine_duty_d,
  input  wire logic [lop_pkg::NUM_CH-1:0]   ext_pwm_sel,
  input  wire logic [lop_pkg::NUM_CH-1:0]   ext_pwm_in,
  output logic                              lamp_out_a,
  output logic                              lamp_out_b,
  output logic                              lamp_out_c,
  output logic                              lamp_out_d
);

  // ==========================================================
  // duty registers
  lop_pkg::lop_duty_pair_t duty_ab_q;
  lop_pkg::lop_duty_pair_t duty_cd_q;
  logic [lop_pkg::DATA_W-1:0] rdata_q;
  logic                       rvalid_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      duty_ab_q <= lop_pkg::DUTY_RESET;
    else if (reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_AB)
      duty_ab_q <= reg_req.wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      duty_cd_q <= lop_pkg::DUTY_RESET;
    else if (reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_CD)
      duty_cd_q <= reg_req.wdata;
  end

  // reads have no side effect; unmapped addresses read as zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rdata_q <= '0;
    else if (reg_req.rd_en)
    begin
      case (reg_req.addr)
        lop_pkg::ADDR_DUTY_AB: rdata_q <= duty_ab_q;
        lop_pkg::ADDR_DUTY_CD: rdata_q <= duty_cd_q;
        default:               rdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= reg_req.rd_en;
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ==========================================================
  // channels
  lop_pkg::lop_chan_cfg_t         cfg [lop_pkg::NUM_CH];
  logic [9:0]                     fine [lop_pkg::NUM_CH];
  logic [lop_pkg::NUM_CH-1:0]     pwm_int;
  logic [lop_pkg::NUM_CH-1:0]     lamp_q;

  assign cfg[0]  = duty_ab_q.hi;
  assign cfg[1]  = duty_ab_q.lo;
  assign cfg[2]  = duty_cd_q.hi;
  assign cfg[3]  = duty_cd_q.lo;
  assign fine[0] = fine_duty_a;
  assign fine[1] = fine_duty_b;
  assign fine[2] = fine_duty_c;
  assign fine[3] = fine_duty_d;

  genvar gi;
  generate
    for (gi = 0; gi < lop_pkg::NUM_CH; gi++)
    begin : g_ch
      lop_pwm_channel u_ch (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .freq_sel    (cfg[gi].freq_sel),
        .fine_en     (fine_resolution_enable),
        .duty_coarse (cfg[gi].duty_field),
        .duty_fine   (fine[gi]),
        .pwm_out     (pwm_int[gi])
      );
    end
  endgenerate

  // ==========================================================
  // output source select
  // external selection wins so a host can override a bad duty setting
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      lamp_q <= '0;
    else
      lamp_q <= (ext_pwm_sel & ext_pwm_in)
              | (~ext_pwm_sel & internal_pwm_source_sel & pwm_int);
  end

  assign lamp_out_a = lamp_q[0];
  assign lamp_out_b = lamp_q[1];
  assign lamp_out_c = lamp_q[2];
  assign lamp_out_d = lamp_q[3];

  // ==========================================================
  // checks
  property p_no_source;
    @(posedge ref_clk) disable iff (reset)
      !ext_pwm_sel[0] && !internal_pwm_source_sel[0] |=> !lamp_out_a;
  endproperty
  a_no_source: assert property (p_no_source) else $error("lamp a driven without source");

  property p_internal;
    @(posedge ref_clk) disable iff (reset)
      !ext_pwm_sel[1] && internal_pwm_source_sel[1] |=> lamp_out_b == $past(pwm_int[1]);
  endproperty
  a_internal: assert property (p_internal) else $error("lamp b not following generator");

  property p_external;
    @(posedge ref_clk) disable iff (reset)
      ext_pwm_sel[2] |=> lamp_out_c == $past(ext_pwm_in[2]);
  endproperty
  a_external: assert property (p_external) else $error("lamp c not following input");

  property p_write_ab;
    @(posedge ref_clk) disable iff (reset)
      reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_AB
      ##1 reg_req.rd_en && !reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_AB
      |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_write_ab: assert property (p_write_ab) else $error("ab readback mismatch");

  property p_write_cd;
    @(posedge ref_clk) disable iff (reset)
      reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_CD
      |=> duty_cd_q == $past(reg_req.wdata);
  endproperty
  a_write_cd: assert property (p_write_cd) else $error("cd write lost");

  property p_reset_clear;
    @(posedge ref_clk)
      $past(reset) |-> duty_ab_q == '0 && duty_cd_q == '0 && !reg_rvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong");

  property p_read_no_effect;
    @(posedge ref_clk) disable iff (reset)
      reg_req.rd_en && !reg_req.wr_en |=> $stable(duty_ab_q) && $stable(duty_cd_q);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read changed a register");

  property p_read_lat;
    @(posedge ref_clk) disable iff (reset)
      reg_req.rd_en |=> reg_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");

  property p_write_ab_lands;
    @(posedge ref_clk) disable iff (reset)
      reg_req.wr_en && reg_req.addr == lop_pkg::ADDR_DUTY_AB
      |=> duty_ab_q == $past(reg_req.wdata);
  endproperty
  a_write_ab_lands: assert property (p_write_ab_lands) else $error("ab write lost");

  property p_unmapped_write;
    @(posedge ref_clk) disable iff (reset)
      reg_req.wr_en && reg_req.addr != lop_pkg::ADDR_DUTY_AB
        && reg_req.addr != lop_pkg::ADDR_DUTY_CD
      |=> $stable(duty_ab_q) && $stable(duty_cd_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

  // read data holds so a slow host may fetch it late
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (reset)
      !reg_req.rd_en
      |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_rvalid_pulse;
    @(posedge ref_clk) disable iff (reset)
      !reg_req.rd_en
      |=> !reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer without read");

  property p_internal_a;
    @(posedge ref_clk) disable iff (reset)
      !ext_pwm_sel[0] && internal_pwm_source_sel[0]
      |=> lamp_out_a == $past(pwm_int[0]);
  endproperty
  a_internal_a: assert property (p_internal_a) else $error("lamp a not following generator");

  c_ext: cover property (@(posedge ref_clk) ext_pwm_sel[2] && ext_pwm_in[2] ##1 lamp_out_c);
  c_int: cover property (@(posedge ref_clk) internal_pwm_source_sel[1] ##1 lamp_out_b);
  c_rd:  cover property (@(posedge ref_clk) reg_rvalid && reg_rdata != '0);

endmodule
`default_nettype wire

//--- bench/lop_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host side of the register port
module lop_host_model (
  input  wire logic                         ref_clk,
  output lop_pkg::lop_reg_req_t             reg_req,
  input  wire logic [lop_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                         reg_rvalid
);
  initial reg_req = '0;
  // one request, then an idle cycle, so a strobe never re-rises in one step
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q, output logic v);
    @(posedge ref_clk);
    reg_req <= '{w, r, a, d};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    q = reg_rdata;
    v = reg_rvalid;
  endtask
  // write then read back on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- bench/lamp_output_pwm_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench for the lamp pwm unit
module lamp_output_pwm_unit_bench;
  logic                  ref_clk = 1'b0;
  logic                  reset   = 1'b1;
  logic [3:0]            isel    = 4'h0;
  logic [3:0]            esel    = 4'h0;
  logic [3:0]            ein     = 4'h0;
  logic                  fine_en = 1'b0;
  logic [9:0]            fd_a    = 10'h000;
  logic [9:0]            fd_b    = 10'h000;
  lop_pkg::lop_reg_req_t reg_req;
  logic [15:0]           rdata;
  logic                  rvalid;
  logic [3:0]            lamp;
  logic [15:0]           q;
  logic                  v;
  int                    fails = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  int                    win = 0;
  int                    hi [4];

  always #5 ref_clk = ~ref_clk;

  lop_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(rdata),
    .reg_rvalid(rvalid));

  lop_lamp_pwm_unit dut (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .internal_pwm_source_sel(isel),
    .fine_resolution_enable(fine_en), .fine_duty_a(fd_a), .fine_duty_b(fd_b),
    .fine_duty_c(fd_a), .fine_duty_d(fd_b), .ext_pwm_sel(esel), .ext_pwm_in(ein),
    .lamp_out_a(lamp[0]), .lamp_out_b(lamp[1]), .lamp_out_c(lamp[2]),
    .lamp_out_d(lamp[3]));

  // ==========================================
  // high time per lamp, window opens as reset drops; a full period is too long
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
    if (!reset)
    begin
      win <= win + 1;
      for (int i = 0; i < 4; i++) hi[i] <= hi[i] + lamp[i];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst(input logic [3:0] sel);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    isel <= sel;
    win = 0;
    hi = '{0, 0, 0, 0};
  endtask

  task automatic wait_win(input int n);
    while (win < n) @(posedge ref_clk);
  endtask

  // ==========================================
  // register map, unmapped place, write and read in one cycle
  task automatic t_regs();
    host.acc(1'b0, 1'b1, 8'h08, 16'h0000, q, v);
    chk(q, 16'h0000);
    host.acc(1'b1, 1'b0, 8'h08, 16'ha55a, q, v);
    host.acc(1'b1, 1'b0, 8'h09, 16'h5aa5, q, v);
    host.acc(1'b1, 1'b0, 8'h0a, 16'hffff, q, v);
    host.acc(1'b0, 1'b1, 8'h08, 16'h0000, q, v);
    chk(q, 16'ha55a);
    host.acc(1'b1, 1'b1, 8'h09, 16'h1234, q, v);
    chk(q, 16'h5aa5);
    host.acc(1'b0, 1'b1, 8'h09, 16'h0000, q, v);
    chk(q, 16'h1234);
    host.acc(1'b0, 1'b1, 8'h0a, 16'h0000, q, v);
    chk({15'h0000, v}, 16'h0001);
    chk(q, 16'h0000);
    host.wr_rd(8'h08, 16'h3c81, q);
    chk(q, 16'h3c81);
  endtask

  // coarse duty and both rates; counters free-run from reset
  task automatic t_coarse();
    rst(4'h7);
    host.acc(1'b0, 1'b1, 8'h09, 16'h0000, q, v);
    chk(q, 16'h0000);
    host.acc(1'b1, 1'b0, 8'h08, 16'h0081, q, v);
    host.acc(1'b1, 1'b0, 8'h09, 16'h8000, q, v);
    wait_win(8000);
    chk(16'(hi[0]), 16'h11f0);
    chk(16'(hi[1]), 16'h1b20);
    chk(16'(hi[2]), 16'h0d90);
    chk(16'(hi[3]), 16'h0000);
  endtask

  // fine duty, external source on lamp c
  task automatic t_fine();
    fine_en <= 1'b1;
    fd_b <= 10'h002;
    rst(4'h3);
    esel <= 4'h4;
    ein <= 4'h4;
    repeat (100) @(posedge ref_clk);
    ein <= 4'h0;
    wait_win(3000);
    chk(16'(hi[0]), 16'h023e);
    chk(16'(hi[1]), 16'h06ba);
    chk(16'(hi[2]), 16'h0064);
    chk(16'(hi[3]), 16'h0000);
  endtask

  task automatic close_out();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_coarse();
    t_fine();
    close_out();
  end
endmodule
`default_nettype wire
